// ===== rtl/sleep_wakeup_pkg.sv
// Constants and types shared by the sleep and wakeup controller
package sleep_wakeup_pkg;
  // ************************************************
  // Register map
  // ************************************************
  localparam logic [3:0] SYS_CTRL_OFFSET = 4'h0;  // system_control_reg
  localparam logic [3:0] STATUS_OFFSET   = 4'h4;  // Sleep status, read only
  // system_control_reg field positions
  localparam int SLEEP_AFTER_BIT  = 1;            // sleep_after_handlers
  localparam int DEEP_SELECT_BIT  = 2;            // deep_sleep_select
  localparam int PEND_EVENT_BIT   = 4;            // pending_irq_event_enable
  localparam logic [31:0] SYS_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SYS_CTRL_MASK  = 32'h00000016;
  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS   = 50;            // 20 MHz core clock
  localparam int DEEP_RESTORE_NS = 2000;          // PLL and flash back on
  localparam int DEEP_RESTORE_CYC =
    (DEEP_RESTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LIGHT_RESTORE_CYC = 1;           // Core clock ungate
  localparam int CNT_W = 8;
  localparam logic EVENT_RESET = 1'b0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {
    ST_RUN, ST_LIGHT, ST_DEEP, ST_WAKE
  } sleep_state_t;
endpackage : sleep_wakeup_pkg

// ===== rtl/sleep_wakeup_control.sv
// Sleep entry, wakeup decision and clock gating for the processor core
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module sleep_wakeup_control #(
  parameter int RESTORE_CYC = sleep_wakeup_pkg::DEEP_RESTORE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side
  input  wire logic        waitIntrInstr,
  input  wire logic        waitEventInstr,
  input  wire logic        handlersDone,
  input  wire logic        excEntryReady,
  input  wire logic        irqAboveCurrent,
  input  wire logic        priorityMaskBit,
  input  wire logic        faultMaskBit,
  input  wire logic        newPendingIrq,
  input  wire logic        debugWake,
  // Far side events
  input  wire logic        extEvent,
  input  wire logic        sendEventIn,
  // Clock controller and core control
  output logic             coreClkEn,
  output logic             sysClkEn,
  output logic             pllOffReq,
  output logic             flashOffReq,
  output logic             coreHalt,
  output logic             handlerDefer,
  output logic             wfeSkip
);
  import sleep_wakeup_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  sleep_state_t     state_q;          // Sleep sequencer
  logic             eventReg_q;       // One-bit event register
  logic             byEvent_q;        // Sleep entered by wait-event
  logic             fromDeep_q;       // Wake follows deep sleep
  logic [CNT_W-1:0] restoreCnt_q;     // Clock restore wait
  logic [31:0]      sysCtrl_q;        // system_control_reg
  logic [3:0]       wakeCause_q;      // Last wake cause, for status
  logic             wfeSkip_q;        // Wait-event skipped pulse
  logic             irqWake;          // Wake usable by any entry
  logic             evtIn;            // Any event source this cycle
  logic             evtWake;          // Extra wakes of wait-event sleep
  logic             wakeNow;          // Wake for the current sleep
  logic             sleepReq;         // Enter sleep this cycle
  logic             wfeSleep;         // Asleep, entered by wait-event
  logic             deep_sleep_select;
  logic             sleepAfter;
  logic             pendEvtEn;

  assign deep_sleep_select  = sysCtrl_q[DEEP_SELECT_BIT];
  assign sleepAfter = sysCtrl_q[SLEEP_AFTER_BIT];
  assign pendEvtEn  = sysCtrl_q[PEND_EVENT_BIT];

  // ************************************************
  // Wakeup conditions
  // ************************************************
  // Exception able to enter, masked wake, or spurious debug wake
  assign irqWake = excEntryReady
                 | (priorityMaskBit & ~faultMaskBit & irqAboveCurrent)
                 | debugWake;
  // Event sources, including newly pending interrupts when enabled
  assign evtIn = extEvent | sendEventIn | (pendEvtEn & newPendingIrq);
  // Wait-event sleep also wakes on a held event
  assign evtWake = evtIn | eventReg_q;
  assign wakeNow = byEvent_q ? (irqWake | evtWake) : irqWake;
  assign wfeSleep = byEvent_q && (state_q == ST_LIGHT || state_q == ST_DEEP);

  // Entry requests; wait-interrupt is skipped when a wake already stands
  assign sleepReq = (waitIntrInstr & ~irqWake)
                  | (waitEventInstr & ~eventReg_q)
                  | (handlersDone & sleepAfter & ~irqWake);

  // ************************************************
  // Sleep sequencer
  // ************************************************
  // Clocks are restored in ST_WAKE before the core runs again
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q      <= ST_RUN;
      byEvent_q    <= 1'b0;
      fromDeep_q   <= 1'b0;
      restoreCnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (sleepReq) begin
            // Depth chosen at entry
            state_q    <= deep_sleep_select ? ST_DEEP : ST_LIGHT;
            fromDeep_q <= deep_sleep_select;
            byEvent_q  <= waitEventInstr & ~eventReg_q;
          end
        end
        ST_LIGHT, ST_DEEP: begin
          if (wakeNow) begin
            state_q      <= ST_WAKE;
            restoreCnt_q <= fromDeep_q ? CNT_W'(RESTORE_CYC)
                                       : CNT_W'(LIGHT_RESTORE_CYC);
          end
        end
        ST_WAKE: begin
          // Wait for PLL and flash before releasing the core
          if (restoreCnt_q <= CNT_W'(1)) begin
            state_q <= ST_RUN;
          end
          restoreCnt_q <= restoreCnt_q - CNT_W'(1);
        end
      endcase
    end
  end

  // ************************************************
  // Event register
  // ************************************************
  // Not mapped on the bus; outside wait-event sleep an event beats a clear.
  // An event that ends wait-event sleep is used up by that wake, so the
  // next wait-event sleeps again; an event landing with an exception wake
  // of wait-event sleep is used up as well, a deliberate simplification.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      eventReg_q <= EVENT_RESET;
    end else if (wfeSleep && wakeNow) begin
      eventReg_q <= 1'b0;
    end else if (evtIn) begin
      eventReg_q <= 1'b1;
    end else if (state_q == ST_RUN && waitEventInstr && eventReg_q) begin
      eventReg_q <= 1'b0;
    end
  end

  // Pulse when a wait-event is skipped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wfeSkip_q <= 1'b0;
    end else begin
      wfeSkip_q <= (state_q == ST_RUN) & waitEventInstr & eventReg_q;
    end
  end

  // Last wake cause: exception, event, debug, pending
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wakeCause_q <= 4'h0;
    end else if ((state_q == ST_LIGHT || state_q == ST_DEEP) && wakeNow) begin
      wakeCause_q <= {pendEvtEn & newPendingIrq, debugWake,
                      byEvent_q & evtWake, irqWake & ~debugWake};
    end
  end

  // ************************************************
  // Clock and power outputs
  // ************************************************
  assign coreClkEn    = (state_q == ST_RUN);
  assign sysClkEn     = (state_q != ST_DEEP);
  assign pllOffReq    = (state_q == ST_DEEP);
  assign flashOffReq  = (state_q == ST_DEEP);
  assign coreHalt     = (state_q != ST_RUN);
  // Handler waits while the priority mask holds and the fault mask is clear
  assign handlerDefer = priorityMaskBit & ~faultMaskBit;
  assign wfeSkip      = wfeSkip_q;

  // ************************************************
  // AXI4-Lite slave
  // ************************************************
  logic        awHeld_q;   // Write address taken
  logic        wHeld_q;    // Write data taken
  logic [3:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic [31:0] rdVal;
  logic        rdHit;

  // Channels taken independently, in either order
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;

  // Capture address and data, answer once both are held
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awHeld_q     <= 1'b0;
      wHeld_q      <= 1'b0;
      awAddr_q     <= 4'h0;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q[3:2] == SYS_CTRL_OFFSET[3:2]) ? RESP_OKAY
                                                                : RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register, byte lane 0 only carries bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sysCtrl_q <= SYS_CTRL_RESET;
    end else if (doWrite && awAddr_q[3:2] == SYS_CTRL_OFFSET[3:2]
                 && wStrb_q[0]) begin
      sysCtrl_q <= {24'h000000, wData_q[7:0]} & SYS_CTRL_MASK;
    end
  end

  // Read decode; status shows state and last wake cause, never the event
  always_comb begin
    rdHit = 1'b1;
    rdVal = 32'h00000000;
    unique case (s_axi_araddr[3:2])
      SYS_CTRL_OFFSET[3:2]: rdVal = sysCtrl_q;
      STATUS_OFFSET[3:2]:   rdVal = {24'h000000, wakeCause_q, 2'h0, state_q};
      default:              rdHit = 1'b0;
    endcase
  end

  // Read answer registered one cycle after the address
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdVal;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  property p_light_clocks;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_LIGHT |-> !coreClkEn && sysClkEn;
  endproperty
  a_light_clocks: assert property (p_light_clocks)
    else $error("Light sleep clock gating wrong");

  property p_deep_power;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_DEEP |-> !sysClkEn && pllOffReq && flashOffReq;
  endproperty
  a_deep_power: assert property (p_deep_power)
    else $error("Deep sleep power requests missing");

  property p_depth_select;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_RUN && sleepReq |=>
        state_q == ($past(deep_sleep_select) ? ST_DEEP : ST_LIGHT);
  endproperty
  a_depth_select: assert property (p_depth_select)
    else $error("Sleep depth does not follow select bit");

  property p_wfi_enter;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_RUN && waitIntrInstr && !irqWake |=> coreHalt;
  endproperty
  a_wfi_enter: assert property (p_wfi_enter)
    else $error("Wait-interrupt did not sleep");

  property p_wfe_skip;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_RUN && waitEventInstr && eventReg_q && !evtIn && !sleepReq
        |=> !eventReg_q && !coreHalt && wfeSkip;
  endproperty
  a_wfe_skip: assert property (p_wfe_skip)
    else $error("Wait-event with event set misbehaved");

  property p_event_set;
    @(posedge clk_sys) disable iff (reset)
      (extEvent || sendEventIn) && !wfeSleep |=> eventReg_q;
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("Event source did not set event register");

  property p_wfe_consume;
    @(posedge clk_sys) disable iff (reset)
      wfeSleep && wakeNow |=> !eventReg_q && state_q == ST_WAKE;
  endproperty
  a_wfe_consume: assert property (p_wfe_consume)
    else $error("Wait-event wake left the event register set");

  property p_wfi_wake;
    @(posedge clk_sys) disable iff (reset)
      (state_q == ST_LIGHT || state_q == ST_DEEP) && !byEvent_q && !irqWake
        |=> state_q != ST_WAKE;
  endproperty
  a_wfi_wake: assert property (p_wfi_wake)
    else $error("Wait-interrupt sleep woke without cause");

  property p_wfe_wake;
    @(posedge clk_sys) disable iff (reset)
      (state_q == ST_LIGHT || state_q == ST_DEEP) && byEvent_q && evtIn
        |=> state_q == ST_WAKE;
  endproperty
  a_wfe_wake: assert property (p_wfe_wake)
    else $error("Wait-event sleep ignored an event");

  property p_restore_first;
    @(posedge clk_sys) disable iff (reset)
      state_q == ST_WAKE ##1 state_q == ST_RUN |-> coreClkEn && sysClkEn && !pllOffReq;
  endproperty
  a_restore_first: assert property (p_restore_first)
    else $error("Core resumed before clocks restored");
endmodule : sleep_wakeup_control

// ===== tb/event_source.sv
// Model of peripherals and a second processor raising wake events
`timescale 1ns/1ns
module event_source (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       fireExt,
  input  wire logic       fireSend,
  input  wire logic [3:0] delay,
  output logic            extEvent,
  output logic            sendEventIn
);
  logic [3:0] cnt_q;   // Cycles still to wait
  logic       busy_q;  // An event is scheduled
  logic       send_q;  // Scheduled event is a send-event
  // ************************************************
  // Event scheduler
  // ************************************************
  // Delay models slow peripherals; both lines rest low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q       <= 4'h0;
      busy_q      <= 1'h0;
      send_q      <= 1'h0;
      extEvent    <= 1'h0;
      sendEventIn <= 1'h0;
    end else begin
      extEvent    <= 1'h0;
      sendEventIn <= 1'h0;
      if (fireExt || fireSend) begin
        // New request replaces a pending one
        cnt_q  <= delay;
        busy_q <= 1'h1;
        send_q <= fireSend;
      end else if (busy_q && cnt_q == 4'h0) begin
        // One-cycle pulse on the chosen line
        extEvent    <= !send_q;
        sendEventIn <= send_q;
        busy_q      <= 1'h0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : event_source

// ===== tb/tb.sv
// Self-checking bench for the sleep and wakeup controller
`timescale 1ns/1ns
module tb;
  import sleep_wakeup_pkg::*;
  localparam int RC = 2;  // Short deep restore keeps the run brief
  localparam logic [4:0] LIGHT = 5'h09;  // Clock outputs, light sleep
  localparam logic [4:0] DEEP  = 5'h07;  // Clock outputs, deep sleep
  localparam logic [4:0] RUN   = 5'h18;  // Clock outputs, running
  logic        clk_sys, reset, priority_mask_bit, fault_mask_bit, fireExt, fireSend;
  logic        haltPrev = 1'h0;  // Halt level at the last falling edge
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, wk, delay;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, extEvent, sendEventIn, coreClkEn;
  logic        sysClkEn, pllOffReq, flashOffReq, coreHalt, handlerDefer, wfeSkip;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  instr;      // Wait-interrupt, wait-event, handlers done
  logic [39:0] notes[$];   // Expected results, oldest first
  int          mismatches = 0, n_tests = 0, seed, i, d;
  wire  [4:0]  outs = {coreClkEn, sysClkEn, pllOffReq, flashOffReq, coreHalt};
  sleep_wakeup_control #(.RESTORE_CYC(RC)) DUT (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .waitIntrInstr(instr[0]),
    .waitEventInstr(instr[1]), .handlersDone(instr[2]), .excEntryReady(wk[0]),
    .irqAboveCurrent(wk[1]), .priorityMaskBit(priority_mask_bit), .faultMaskBit(fault_mask_bit),
    .newPendingIrq(wk[3]), .debugWake(wk[2]), .extEvent, .sendEventIn, .coreClkEn,
    .sysClkEn, .pllOffReq, .flashOffReq, .coreHalt, .handlerDefer, .wfeSkip);
  event_source EVT (.clk_sys, .reset, .fireExt, .fireSend, .delay, .extEvent,
    .sendEventIn);
  // ************************************************
  // Checking and closing
  // ************************************************
  task automatic end_sim;
    $display("Mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang;
    mismatches++;
    $display("CHECK FAILED %0t: no answer in time", $time);
    end_sim();
  endtask : hang
  // Oldest note against what was seen; an empty queue means unexpected
  task automatic take(input logic [39:0] seen);
    logic [39:0] exp;
    exp = 40'h0;
    if (notes.size() > 0) exp = notes.pop_front();
    check(seen, exp);
  endtask : take
  task automatic note(input logic [3:0] k, input logic [35:0] v);
    notes.push_back({k, v});
  endtask : note
  // ************************************************
  // Drivers
  // ************************************************
  // One bus transfer; handshakes sampled on the falling edge, released after rise
  task automatic axi(input logic rd, input logic [3:0] a, input logic [31:0] v,
                     input logic [1:0] r);
    logic aw, w, ar, done;
    int   k;
    done = 1'h0;
    note(rd ? 4'h2 : 4'h1, {2'h0, r, rd ? v : 32'h0});
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= !rd;
    s_axi_wvalid  <= !rd;
    s_axi_bready  <= !rd;
    s_axi_arvalid <= rd;
    s_axi_rready  <= rd;
    for (k = 0; k < 50 && !done; k++) begin
      @(negedge clk_sys);
      aw   = s_axi_awvalid && s_axi_awready;
      w    = s_axi_wvalid && s_axi_wready;
      ar   = s_axi_arvalid && s_axi_arready;
      done = rd ? s_axi_rvalid : s_axi_bvalid;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
      if (done) {s_axi_bready, s_axi_rready} <= 2'h0;
    end
    if (!done) hang();
    @(posedge clk_sys);
  endtask : axi
  task automatic pulse(input int idx);
    instr <= 3'h1 << idx;
    @(posedge clk_sys);
    instr <= 3'h0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic sleep(input int idx, input logic [4:0] code);
    note(4'h3, {31'h0, code});
    pulse(idx);
  endtask : sleep
  task automatic fire_ev(input logic [1:0] f);
    delay    <= 4'h0;
    fireExt  <= f[0];
    fireSend <= f[1];
    @(posedge clk_sys);
    {fireExt, fireSend} <= 2'h0;
    repeat (4) @(posedge clk_sys);
  endtask : fire_ev
  // Raise a wake source for one cycle and time the return to running
  task automatic wake(input logic [3:0] src, input logic [1:0] f, input int expK);
    logic done;
    int   k;
    done = 1'h0;
    note(4'h3, {31'h0, RUN});
    wk       <= src;
    fireExt  <= f[0];
    fireSend <= f[1];
    for (k = 1; k < 60 && !done; k++) begin
      @(negedge clk_sys);
      done = !coreHalt;
      if (done) check(40'(k), 40'(expK));
      @(posedge clk_sys);
      {wk, fireExt, fireSend} <= 6'h00;
    end
    if (!done) hang();
    @(posedge clk_sys);
  endtask : wake
  // ************************************************
  // Result monitor
  // ************************************************
  always @(negedge clk_sys) begin
    if (!reset) begin
      if (s_axi_bvalid && s_axi_bready) take({4'h1, 2'h0, s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) take({4'h2, 2'h0, s_axi_rresp, s_axi_rdata});
      if (coreHalt !== haltPrev) take({4'h3, 31'h0, outs});
      if (wfeSkip === 1'h1) take({4'h4, 36'h1});
      haltPrev = coreHalt;
    end
  end
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    reset = 1'h1;
    seed = 34173;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;  // Full words only
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {instr, wk, priority_mask_bit, fault_mask_bit, fireExt, fireSend} = 11'h000;
    delay = 4'h0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    // Reset values, decode, refused writes, random control values
    axi(1'h1, SYS_CTRL_OFFSET, SYS_CTRL_RESET, RESP_OKAY);
    axi(1'h1, STATUS_OFFSET, 32'h0, RESP_OKAY);
    axi(1'h1, 4'h8, 32'h0, RESP_DECERR);
    axi(1'h0, STATUS_OFFSET, 32'h0, RESP_DECERR);
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      axi(1'h0, SYS_CTRL_OFFSET, rnd, RESP_OKAY);
      axi(1'h1, SYS_CTRL_OFFSET, rnd & SYS_CTRL_MASK, RESP_OKAY);
    end
    // Light sleep by wait-interrupt; an event alone must not end it
    axi(1'h0, SYS_CTRL_OFFSET, 32'h0, RESP_OKAY);
    sleep(0, LIGHT);
    fire_ev(2'h1);
    wake(4'h1, 2'h0, 3);
    // Stored event: first wait-event runs on, the next one sleeps
    note(4'h4, 36'h1);
    pulse(1);
    sleep(1, LIGHT);
    d = $random(seed) & 3;
    delay <= d[3:0];
    wake(4'h0, 2'h2, 5 + d);
    sleep(1, LIGHT);
    wake(4'h0, 2'h1, 5 + d);
    // Wake already true, or handlers done with the option off: no sleep
    wk <= 4'h1;
    pulse(0);
    wk <= 4'h0;
    pulse(2);
    // New pending interrupt wakes wait-event sleep only when enabled
    sleep(1, LIGHT);
    wk <= 4'h8;
    @(posedge clk_sys);
    wk <= 4'h0;
    repeat (3) @(posedge clk_sys);
    axi(1'h0, SYS_CTRL_OFFSET, 32'h10, RESP_OKAY);
    wake(4'h8, 2'h0, 3);
    // Sleep after handlers, woken by a masked interrupt
    axi(1'h0, SYS_CTRL_OFFSET, 32'h2, RESP_OKAY);
    priority_mask_bit <= 1'h1;
    sleep(2, LIGHT);
    check({39'h0, handlerDefer}, 40'h1);
    wake(4'h2, 2'h0, 3);
    fault_mask_bit <= 1'h1;
    @(posedge clk_sys);
    check({39'h0, handlerDefer}, 40'h0);
    {priority_mask_bit, fault_mask_bit} <= 2'h0;
    // Deep sleep ended by a debug wake, with the longer restore
    axi(1'h0, SYS_CTRL_OFFSET, 32'h4, RESP_OKAY);
    sleep(0, DEEP);
    wake(4'h4, 2'h0, 2 + RC);
    axi(1'h1, STATUS_OFFSET, 32'h40, RESP_OKAY);
    check(40'(notes.size()), 40'h0);
    end_sim();
  end
endmodule : tb
